// ### inc/wdr_pkg.sv
/*
 * Constants and types shared by the watchdog and reset-flag block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and a 32-bit APB register bus.
 */
package wdr_pkg;

   // -------------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS       = 40;
   localparam int SLOW_CLOCK_HZ       = 32000;
   localparam int SW_RESET_DELAY_NS   = 100000;
   localparam int LV_QUALIFY_NS       = 120000;
   // A least time rounds up to whole system clock cycles.
   localparam int SW_RESET_DELAY_CYC  =
      (SW_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LV_QUALIFY_CYC      =
      (LV_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_W             = 12;
   localparam int WD_COUNT_W          = 19;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_FLAGS  = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;

   // watchdog_control fields and power-on value.
   localparam int         KEY_MSB       = 7;
   localparam int         KEY_LSB       = 3;
   localparam int         PERIOD_MSB    = 2;
   localparam int         PERIOD_LSB    = 0;
   localparam logic [7:0] CTRL_RST      = 8'h53;
   localparam logic [4:0] KEY_ENABLE_A  = 5'h0A;
   localparam logic [4:0] KEY_ENABLE_B  = 5'h15;

   // reset_cause_flags fields.
   localparam int KEY_FLAG_BIT = 0;
   localparam int LV_FLAG_BIT  = 2;

   // Status register fields.
   localparam int TO_FLAG_BIT   = 0;
   localparam int PD_FLAG_BIT   = 1;
   localparam int KEY_VALID_BIT = 2;

   // Power-of-two tap for each period_select code.
   localparam logic [4:0] TAP_0 = 5'h08;
   localparam logic [4:0] TAP_1 = 5'h0A;
   localparam logic [4:0] TAP_2 = 5'h0C;
   localparam logic [4:0] TAP_3 = 5'h0E;
   localparam logic [4:0] TAP_4 = 5'h0F;
   localparam logic [4:0] TAP_5 = 5'h10;
   localparam logic [4:0] TAP_6 = 5'h11;
   localparam logic [4:0] TAP_7 = 5'h12;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic {
      WDR_KEY_OK   = 1'b0,
      WDR_KEY_WAIT = 1'b1
   } wdr_key_state_t;

endpackage : wdr_pkg

// ### design/wdr_watchdog.sv
/*
 * Watchdog timer with enable key, period select and reset-cause flags,
 * plus low-voltage reset qualification, behind an APB slave.
 * Assumes the slow oscillator arrives as a level synchronous to ref_clk,
 * the core pulses clrWdt and haltExec for one cycle per instruction, and
 * the analogue low-voltage detector drives lowVoltage.
 */
// The register addresses and register access over APB were left to the implementer.
//Contract
//- Watchdog counter advances only on slow oscillator edges, not system clock.
//- Period code selects timeout of 2^8,10,12,14,15,16,17,18 slow cycles.
//- Watchdog runs only while key field holds 01010 or 10101.
//- Any other key value causes full reset after software reset delay.
//- Key reset sets bit 0 flag; only software writes clear it.
//- After power-on control holds key 01010 and period 011.
//- Overflow in normal operation causes full reset and sets timeout flag.
//- Overflow in sleep or idle sets timeout flag, resets only PC and SP.
//- Counter cleared by key reset, clear instruction or halt instruction.
//- Flag register bits 7 to 3 and bit 1 read zero.
//- Power-on reset sets program counter to zero.
//- Power-on reset presets all port data and control registers to ones.
//- Qualified low-voltage indication resets device and sets low-voltage flag.
//- Low-voltage indication not exceeding qualify time is ignored.
//- Low-voltage detection disabled in sleep or idle mode.
//- Halt sets power-down flag, clears timeout flag, clears counter.
//- Power-down flag cleared by power-up or clear instruction.
//- Power-on clears both flags; sleep overflow leaves both at one.
`timescale 1ns/1ps
module wdr_watchdog
   import wdr_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic                clkEn,
   input  wire logic                slowClk,
   input  wire logic                clrWdt,
   input  wire logic                haltExec,
   input  wire logic                lowPowerMode,
   input  wire logic                lowVoltage,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output wire logic [31:0]         prdata,
   output wire logic                pready,
   output wire logic                pslverr,
   output wire logic                fullResetReq,
   output wire logic                pcSpReset,
   output wire logic                progCounterZero,
   output wire logic                portPreset,
   output wire logic                timeoutFlag,
   output wire logic                powerDownFlag
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]            ctrl;
      logic                  keyFlag;
      logic                  lvFlag;
      logic                  toFlag;
      logic                  pdFlag;
      logic [WD_COUNT_W-1:0] wdCount;
      logic                  slowPrev;
      wdr_key_state_t        keyState;
      logic [DELAY_W-1:0]    swDelay;
      logic [DELAY_W-1:0]    lvCount;
      logic                  lvFired;
      logic                  fullRst;
      logic                  pcSpRst;
      logic                  pcZero;
      logic                  portSet;
      logic [31:0]           rdata;
      logic                  slvErr;
   } wdr_state_t;

   wdr_state_t st;
   wdr_state_t next_st;

   logic [4:0]            keyField;
   logic                  keyValid;
   logic                  slowRise;
   logic [4:0]            tapBit;
   logic [WD_COUNT_W-1:0] incCount;
   logic                  ovEvt;
   logic                  ovNormal;
   logic                  ovSleep;
   logic                  keyFire;
   logic                  lvTrig;
   logic                  fullEvt;
   logic                  setupPh;
   logic                  wrEn;

   localparam logic [DELAY_W-1:0] SW_LAST =
      DELAY_W'(SW_RESET_DELAY_CYC - 1);
   localparam logic [DELAY_W-1:0] LV_LIMIT = DELAY_W'(LV_QUALIFY_CYC);

   // Every check below belongs to the one system clock domain.
   default clocking wdrCb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // -------------------------------------------------------------------
   // Events
   // -------------------------------------------------------------------
   function automatic logic [4:0] tap_of(input logic [2:0] code);
      logic [4:0] t;
      t = TAP_0;
      unique case (code)
         3'h0: t = TAP_0;
         3'h1: t = TAP_1;
         3'h2: t = TAP_2;
         3'h3: t = TAP_3;
         3'h4: t = TAP_4;
         3'h5: t = TAP_5;
         3'h6: t = TAP_6;
         3'h7: t = TAP_7;
      endcase
      return t;
   endfunction : tap_of

   assign keyField = st.ctrl[KEY_MSB:KEY_LSB];
   assign keyValid = (keyField == KEY_ENABLE_A) ||
                     (keyField == KEY_ENABLE_B);
   assign slowRise = slowClk && !st.slowPrev;
   assign tapBit   = tap_of(st.ctrl[PERIOD_MSB:PERIOD_LSB]);
   assign incCount = st.wdCount + WD_COUNT_W'(1);
   // Overflow fires once, on the step that first sets the tap bit.
   assign ovEvt    = clkEn && slowRise && keyValid && !clrWdt &&
                     !haltExec && incCount[tapBit];
   assign ovNormal = ovEvt && !lowPowerMode;
   assign ovSleep  = ovEvt && lowPowerMode;
   assign keyFire  = clkEn && (st.keyState == WDR_KEY_WAIT) &&
                     (st.swDelay == SW_LAST);
   // A drop must outlast the qualify count by one cycle to count.
   assign lvTrig   = clkEn && !lowPowerMode && lowVoltage &&
                     !st.lvFired && (st.lvCount == LV_LIMIT);
   assign fullEvt  = ovNormal || keyFire || lvTrig;
   assign setupPh  = psel && !penable;
   assign wrEn     = psel && penable && pwrite && clkEn;

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (clkEn) begin
         next_st.fullRst  = fullEvt;
         next_st.pcSpRst  = ovSleep;
         next_st.pcZero   = fullEvt || ovSleep;
         next_st.portSet  = fullEvt;
         next_st.slowPrev = slowClk;

         if (!keyValid || clrWdt || haltExec || ovEvt) begin
            next_st.wdCount = '0;
         end else if (slowRise) begin
            next_st.wdCount = incCount;
         end

         // Once a bad key is seen the reset goes ahead even if
         // software restores a valid key during the delay.
         unique case (st.keyState)
            WDR_KEY_OK: begin
               next_st.swDelay = '0;
               if (!keyValid) begin
                  next_st.keyState = WDR_KEY_WAIT;
               end
            end
            WDR_KEY_WAIT: begin
               next_st.swDelay = st.swDelay + DELAY_W'(1);
            end
         endcase

         if (lowPowerMode || !lowVoltage) begin
            next_st.lvCount = '0;
            next_st.lvFired = 1'b0;
         end else if (lvTrig) begin
            next_st.lvFired = 1'b1;
         end else if (!st.lvFired) begin
            next_st.lvCount = st.lvCount + DELAY_W'(1);
         end

         if (clrWdt) begin
            next_st.pdFlag = 1'b0;
         end
         if (haltExec) begin
            next_st.pdFlag = 1'b1;
            next_st.toFlag = 1'b0;
         end
         if (ovEvt) begin
            next_st.toFlag = 1'b1;
         end

         if (wrEn && paddr == ADDR_CTRL) begin
            next_st.ctrl = pwdata[7:0];
         end
         if (wrEn && paddr == ADDR_FLAGS) begin
            next_st.keyFlag = pwdata[KEY_FLAG_BIT];
            next_st.lvFlag  = pwdata[LV_FLAG_BIT];
         end
         // Hardware sets win over a clearing write in the same cycle.
         if (keyFire) begin
            next_st.keyFlag = 1'b1;
         end
         if (lvTrig) begin
            next_st.lvFlag = 1'b1;
         end
         if (fullEvt) begin
            next_st.ctrl     = CTRL_RST;
            next_st.wdCount  = '0;
            next_st.keyState = WDR_KEY_OK;
            next_st.swDelay  = '0;
         end

         if (setupPh) begin
            next_st.slvErr = 1'b0;
            unique case (paddr)
               ADDR_CTRL:   next_st.rdata = {24'h00_0000, st.ctrl};
               ADDR_FLAGS: begin
                  next_st.rdata = '0;
                  next_st.rdata[KEY_FLAG_BIT] = st.keyFlag;
                  next_st.rdata[LV_FLAG_BIT]  = st.lvFlag;
               end
               ADDR_STATUS: begin
                  next_st.rdata = '0;
                  next_st.rdata[TO_FLAG_BIT]   = st.toFlag;
                  next_st.rdata[PD_FLAG_BIT]   = st.pdFlag;
                  next_st.rdata[KEY_VALID_BIT] = keyValid;
               end
               default: begin
                  next_st.rdata  = '0;
                  next_st.slvErr = 1'b1;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st          <= '0;
         st.ctrl     <= CTRL_RST;
         st.toFlag   <= 1'b0;
         st.pdFlag   <= 1'b0;
         st.keyState <= WDR_KEY_OK;
         st.pcZero   <= 1'b1;
         st.portSet  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Zero wait states: read data is captured in the setup cycle.
   assign pready          = psel && penable && clkEn;
   assign prdata          = st.rdata;
   assign pslverr         = psel && penable && st.slvErr;
   assign fullResetReq    = st.fullRst;
   assign pcSpReset       = st.pcSpRst;
   assign progCounterZero = st.pcZero;
   assign portPreset      = st.portSet;
   assign timeoutFlag     = st.toFlag;
   assign powerDownFlag   = st.pdFlag;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   AST_SLOW_ONLY: assert property (
      clkEn && !slowRise && !fullEvt |=> $stable(st.wdCount) ||
      st.wdCount == '0)
      else $error("Watchdog count moved without a slow clock edge.");

   AST_TAP: assert property (
      ovEvt |-> st.wdCount == (WD_COUNT_W'(1) << tapBit) - 1'b1)
      else $error("Overflow at the wrong count for the period.");

   AST_KEY_EN: assert property (
      clkEn && !keyValid |=> st.wdCount == '0)
      else $error("Watchdog counted with an invalid key.");

   AST_KEY_RST: assert property (
      keyFire |=> fullResetReq && st.keyFlag &&
      st.ctrl == CTRL_RST)
      else $error("Key reset did not reset the device.");

   AST_KEY_FLAG: assert property (
      st.keyFlag && !(wrEn && paddr == ADDR_FLAGS) |=> st.keyFlag)
      else $error("Key reset flag cleared without a write.");

   AST_POR: assert property (
      $rose(resetn) |-> st.ctrl == CTRL_RST && !timeoutFlag &&
      !powerDownFlag && progCounterZero && portPreset)
      else $error("Power-on state is wrong.");

   AST_WD_NORMAL: assert property (
      ovNormal |=> fullResetReq && timeoutFlag && !pcSpReset)
      else $error("Normal overflow did not reset the device.");

   AST_WD_SLEEP: assert property (
      ovSleep && st.pdFlag |=> pcSpReset && progCounterZero &&
      !fullResetReq && timeoutFlag && powerDownFlag)
      else $error("Sleep overflow did more than a PC reset.");

   AST_HALT: assert property (
      clkEn && haltExec && !ovEvt |=> powerDownFlag &&
      !timeoutFlag && st.wdCount == '0)
      else $error("Halt did not set the power-down state.");

   AST_CLR: assert property (
      clkEn && clrWdt && !haltExec |=> !powerDownFlag &&
      st.wdCount == '0)
      else $error("Clear instruction left the power-down flag.");

   AST_RSV: assert property (
      setupPh && clkEn && paddr == ADDR_FLAGS |=>
      prdata[7:3] == 5'h00 && prdata[1] == 1'b0)
      else $error("Unimplemented flag bits read non-zero.");

   AST_LV: assert property (
      lvTrig |=> fullResetReq && st.lvFlag)
      else $error("Qualified low voltage did not reset.");

   AST_LV_SHORT: assert property (
      lvTrig |-> $past(lowVoltage) && st.lvCount == LV_LIMIT)
      else $error("Short low-voltage glitch caused a reset.");

   AST_LV_SLEEP: assert property (
      lowPowerMode |-> !lvTrig)
      else $error("Low-voltage reset fired in a low-power mode.");

   COV_NORMAL_OV: cover property (ovNormal);
   COV_SLEEP_OV: cover property (ovSleep && st.pdFlag);
   COV_KEY_RST: cover property (keyFire);
   COV_LV_RST: cover property (lvTrig);

endmodule : wdr_watchdog

// ### dv/wdr_core_model.sv
/*
 * Core-side partner of the watchdog block: a free-running slow oscillator
 * level and the clear-watchdog and halt instruction pulses.
 * Assumes a single ref_clk domain; the bench calls the tasks by hierarchy.
 */
`timescale 1ns/1ps
module wdr_core_model
   import wdr_pkg::*;
#(
   parameter int SLOW_DIV = 4
)(
   input  wire logic ref_clk,
   output logic      slowClk,
   output logic      clrWdt,
   output logic      haltExec
);

   int divCount;

   initial begin
      clrWdt   = 1'b0;
      haltExec = 1'b0;
   end

   // ----------------------------------------------------------------
   // Slow oscillator
   // ----------------------------------------------------------------
   // Far faster than the real oscillator, so that timeouts stay short.
   always @(posedge ref_clk) begin
      divCount <= (divCount + 1) % SLOW_DIV;
      slowClk  <= (divCount >= SLOW_DIV / 2);
   end

   // ----------------------------------------------------------------
   // Instruction pulses
   // ----------------------------------------------------------------
   // Each pulse lasts one cycle, as one executed instruction does.
   task automatic issue_clear();
      @(posedge ref_clk);
      clrWdt <= 1'b1;
      @(posedge ref_clk);
      clrWdt <= 1'b0;
   endtask : issue_clear

   task automatic issue_halt();
      @(posedge ref_clk);
      haltExec <= 1'b1;
      @(posedge ref_clk);
      haltExec <= 1'b0;
   endtask : issue_halt

endmodule : wdr_core_model

// ### dv/tb_top.sv
/*
 * Self-checking bench for the watchdog and reset-flag block: APB tasks,
 * a core partner model and directed tests of timeouts and reset causes.
 * Assumes the design package constants and zero-wait APB answers.
 */
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("FAIL %s expected %0h seen %0h", name, exp, got); \
      end \
   end
module tb_top
   import wdr_pkg::*;
;
   localparam int SLOW_DIV = 4;

   logic              ref_clk;
   logic              resetn;
   logic              lowPowerMode;
   logic              lowVoltage;
   logic              clkEn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              fullResetReq;
   logic              pcSpReset;
   logic              progCounterZero;
   logic              portPreset;
   logic              timeoutFlag;
   logic              powerDownFlag;
   logic              slowClk;
   logic              clrWdt;
   logic              haltExec;
   logic [31:0]       rdData;
   logic              rdErr;
   logic              sawFull;
   logic              sawPcSp;
   logic              sawPreset;
   logic              sawPcZero;
   int                cyc;
   int                mismatches;
   int                num_checks;

   wdr_core_model #(.SLOW_DIV(SLOW_DIV)) core (
      .ref_clk (ref_clk),
      .slowClk (slowClk),
      .clrWdt  (clrWdt),
      .haltExec(haltExec)
   );

   // The clock enable is driven so that one test can freeze the block.
   wdr_watchdog DUT (
      .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
      .slowClk(slowClk), .clrWdt(clrWdt), .haltExec(haltExec),
      .lowPowerMode(lowPowerMode), .lowVoltage(lowVoltage),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fullResetReq(fullResetReq),
      .pcSpReset(pcSpReset), .progCounterZero(progCounterZero),
      .portPreset(portPreset), .timeoutFlag(timeoutFlag),
      .powerDownFlag(powerDownFlag)
   );

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                           input logic [31:0] d);
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb_xfer

   // A reset pulse lasts one cycle, so every edge is looked at.
   task automatic wait_reset(input int maxCyc);
      cyc = 0;
      do begin
         @(posedge ref_clk);
         cyc++;
      end while (fullResetReq !== 1'b1 && pcSpReset !== 1'b1 &&
                 cyc < maxCyc);
      sawFull   = fullResetReq;
      sawPcSp   = pcSpReset;
      sawPreset = portPreset;
      sawPcZero = progCounterZero;
   endtask : wait_reset

   task automatic chk_range(input string name, input int lo, input int hi);
      `CHK(name, 1'b1, (cyc >= lo && cyc <= hi))
   endtask : chk_range

   task automatic chk_read(input logic [ADDR_W-1:0] a,
                           input logic [31:0] exp);
      apb_xfer(1'b0, a, 32'h0000_0000);
      `CHK("read data", exp, rdData)
   endtask : chk_read

   task automatic run_period(input logic [7:0] ctrl, input int tap);
      apb_xfer(1'b1, ADDR_CTRL, {24'h00_0000, ctrl});
      core.issue_clear();
      wait_reset((1 << tap) * SLOW_DIV + 50);
      `CHK("overflow full reset", 1'b1, sawFull)
      chk_range("timeout", ((1 << tap) - 2) * SLOW_DIV,
                ((1 << tap) + 2) * SLOW_DIV);
      `CHK("port preset", 1'b1, sawPreset)
      `CHK("pc zero", 1'b1, sawPcZero)
      chk_read(ADDR_CTRL, 32'h0000_0053);
      chk_read(ADDR_STATUS, 32'h0000_0005);
   endtask : run_period

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      mismatches   = 0;
      num_checks   = 0;
      resetn       = 1'b0;
      lowPowerMode = 1'b0;
      lowVoltage   = 1'b0;
      clkEn        = 1'b1;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = '0;
      pwdata       = 32'h0000_0000;
      repeat (5) @(posedge ref_clk);
      `CHK("pc zero in reset", 1'b1, progCounterZero)
      `CHK("preset in reset", 1'b1, portPreset)
      resetn <= 1'b1;
      chk_read(ADDR_CTRL, 32'h0000_0053);
      chk_read(ADDR_FLAGS, 32'h0000_0000);
      chk_read(ADDR_STATUS, 32'h0000_0004);
      chk_read(12'h00C, 32'h0000_0000);
      `CHK("unmapped error", 1'b1, rdErr)
      run_period(8'h50, 8);
      run_period(8'hA9, 10);
      // Regular clears keep the shortest period from running out.
      apb_xfer(1'b1, ADDR_CTRL, 32'h0000_0050);
      repeat (3) begin
         core.issue_clear();
         wait_reset(200 * SLOW_DIV);
         `CHK("no reset when cleared", 1'b0, sawFull | sawPcSp)
      end
      // A low clock enable freezes the count past the shortest timeout.
      core.issue_clear();
      clkEn <= 1'b0;
      wait_reset(1500);
      `CHK("frozen by clock enable", 1'b0, sawFull | sawPcSp)
      clkEn <= 1'b1;
      core.issue_halt();
      wait_reset(200 * SLOW_DIV);
      `CHK("no reset after halt", 1'b0, sawFull | sawPcSp)
      chk_read(ADDR_STATUS, 32'h0000_0006);
      `CHK("power-down flag set", 1'b1, powerDownFlag)
      `CHK("timeout flag cleared", 1'b0, timeoutFlag)
      core.issue_clear();
      chk_read(ADDR_STATUS, 32'h0000_0004);
      lowPowerMode <= 1'b1;
      core.issue_halt();
      wait_reset(256 * SLOW_DIV + 50);
      `CHK("sleep pc/sp reset", 1'b1, sawPcSp)
      `CHK("sleep no full reset", 1'b0, sawFull)
      `CHK("sleep pc zero", 1'b1, sawPcZero)
      `CHK("sleep no preset", 1'b0, sawPreset)
      chk_read(ADDR_STATUS, 32'h0000_0007);
      `CHK("sleep timeout flag", 1'b1, timeoutFlag)
      `CHK("sleep power-down flag", 1'b1, powerDownFlag)
      lowPowerMode <= 1'b0;
      core.issue_clear();
      chk_read(ADDR_STATUS, 32'h0000_0005);
      `CHK("power-down flag cleared", 1'b0, powerDownFlag)
      // A bad key forces a delayed reset and latches its flag.
      apb_xfer(1'b1, ADDR_CTRL, 32'h0000_0003);
      wait_reset(SW_RESET_DELAY_CYC + 50);
      `CHK("key reset", 1'b1, sawFull)
      chk_range("key delay", SW_RESET_DELAY_CYC,
                SW_RESET_DELAY_CYC + 3);
      chk_read(ADDR_FLAGS, 32'h0000_0001);
      chk_read(ADDR_CTRL, 32'h0000_0053);
      apb_xfer(1'b1, ADDR_FLAGS, 32'h0000_0000);
      chk_read(ADDR_FLAGS, 32'h0000_0000);
      lowVoltage <= 1'b1;
      wait_reset(100);
      `CHK("short dip ignored", 1'b0, sawFull)
      lowVoltage   <= 1'b0;
      lowPowerMode <= 1'b1;
      @(posedge ref_clk);
      lowVoltage <= 1'b1;
      wait_reset(LV_QUALIFY_CYC + 200);
      `CHK("no lv reset asleep", 1'b0, sawFull | sawPcSp)
      lowVoltage   <= 1'b0;
      lowPowerMode <= 1'b0;
      @(posedge ref_clk);
      lowVoltage <= 1'b1;
      wait_reset(LV_QUALIFY_CYC + 50);
      `CHK("lv reset", 1'b1, sawFull)
      chk_range("lv qualify", LV_QUALIFY_CYC, LV_QUALIFY_CYC + 4);
      lowVoltage <= 1'b0;
      chk_read(ADDR_FLAGS, 32'h0000_0004);
      test_done();
   end

   // The tests need some 20000 cycles; twice that means a hang.
   initial begin
      #(40 * 40000);
      mismatches++;
      test_done();
   end

endmodule : tb_top
